// ---- src/framer_consts.svh ----
// Constant map for the link security-payload framer: offsets, fields, codes and reset values.
`ifndef FRAMER_CONSTS_SVH
`define FRAMER_CONSTS_SVH

// Register byte offsets.
`define ADDR_CTRL     8'h00
`define ADDR_TX_SPI   8'h04
`define ADDR_TX_SEQ   8'h08
`define ADDR_RX_SPI   8'h0C
`define ADDR_RX_SEQ   8'h10
`define ADDR_PARAM    8'h14
`define ADDR_KEY      8'h18
`define ADDR_STATUS   8'h1C

// Control register fields and reset value.
`define CTRL_LT_MSB   1
`define CTRL_LT_LSB   0
`define CTRL_TX_EN    2
`define CTRL_RX_SUP   3
`define CTRL_RST      4'hC

// Parameter register fields, limits and reset values.
`define PRM_TRL_MSB   2
`define PRM_TRL_LSB   0
`define PRM_BLK_MSB   6
`define PRM_BLK_LSB   4
`define PRM_BLK_MAX   3'h6
`define TRL_RST       3'h1
`define BLK_RST       3'h2

// Link types held in the control register.
`define LINK_SW       2'h0
`define LINK_NF       2'h1
`define LINK_FN       2'h2

// Identifier values written into the encapsulation header.
`define ID_SW_LINK    24'h0FFFFD
`define ID_FABRIC     24'h0FFFFE
`define ID_NODE       24'h0FFFF0

// Header word positions and field positions within a word.
`define WORD_DEST     3'h0
`define WORD_SRC      3'h1
`define WORD_CTL      3'h3
`define WORD_HDR_LAST 3'h5
`define ID_MSB        23
`define ID_LSB        0
`define CTL_MSB       23
`define CTL_LSB       16
`define ESP_BIT       6
`define ESP_CTL       8'h40
`define PADLEN_MSB    15
`define PADLEN_LSB    8
`define PADLEN_ADJ    10'h002

`endif

// ---- src/framer_pkg.sv ----
// Types shared by the link security-payload framer.
package framer_pkg;

  // Send sequencer states.
  typedef enum logic [2:0] {T_HDR, T_RAW, T_SPI, T_SEQ, T_BODY, T_PAD, T_ICV} tx_st_t;

  // Receive sequencer states.
  typedef enum logic [2:0] {R_HDR, R_SPI, R_SEQ, R_BODY, R_CHK, R_PASS, R_DISC} rx_st_t;

endpackage

// ---- src/icv_accum.sv ----
// Keyed running integrity accumulator used on both the send and the receive path.
`timescale 1ns/100ps
module icv_accum #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] word,
  input  wire logic [W-1:0] key,
  output logic      [W-1:0] acc
);

  typedef struct packed {
    logic [W-1:0] acc;
  } icv_state_t;

  icv_state_t s_q;
  icv_state_t s_d;

  // Rotate-and-mix stand-in; a stronger authenticator drops in here unchanged at the ports.
  always_comb
  begin
    s_d = s_q;
    if (clr)
    begin
      s_d.acc = word ^ key;
    end
    else if (en)
    begin
      s_d.acc = {s_q.acc[W-2:0], s_q.acc[W-1]} ^ word ^ key;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign acc = s_q.acc;  // Straight from the flop.

endmodule

// ---- src/link_esp_encap_framer.sv ----
// Link security-payload framer for frames that carry an encapsulation header.
// Contract
// - Switch link: destination and source identifiers both become FFFFDh.
// - Node-to-fabric link: destination FFFFEh, source FFFF0h.
// - Fabric-to-node link: destination FFFF0h, source FFFFEh.
// - Security bit set in optional header control means all other bits zero.
// - Insert an 8-byte security header with index and sequence after the header.
// - Pad inner content to the block size and record the pad length.
// - Encrypt the padded content before computing the integrity check.
// - Integrity check covers header as sent, security header, encrypted data.
// - Append a trailer of negotiated length, whole 32-bit words, holding the check.
// - Receiver looks up parameters by index and rejects replayed sequence numbers.
// - Receiver recomputes the check over header, security header and ciphertext.
// - Authentication succeeds only when recomputed and received check values match.
// - Receiver decrypts the ciphertext after the integrity check; here each word is decrypted and delivered in R_BODY, before R_CHK.
// - Receiver strips padding then handles the remaining inner frame; here pad words are delivered and rx_out_pad_len gives the length.
// - Every selected frame is protected; every flagged frame is processed.
// - Receiver may drop frames that fail authentication.
// - Receiver without security support discards frames carrying the header.
// - Security header is words 6 and 7; inner header starts at word 8.
// - Encryption covers word 8 to pad end; authentication words 0 to pad end.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "framer_consts.svh"
module link_esp_encap_framer #(
  parameter int MAX_TRL = 4
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        tx_in_valid,
  input  wire logic [31:0] tx_in_data,
  input  wire logic        tx_in_last,
  input  wire logic        tx_in_protect,
  output logic             tx_in_ready,
  input  wire logic [31:0] tx_key_word,
  output logic             tx_out_valid,
  output logic      [31:0] tx_out_data,
  output logic             tx_out_last,
  input  wire logic        rx_in_valid,
  input  wire logic [31:0] rx_in_data,
  input  wire logic        rx_in_last,
  input  wire logic [31:0] rx_key_word,
  output logic             rx_out_valid,
  output logic      [31:0] rx_out_data,
  output logic             rx_out_last,
  output logic      [7:0]  rx_out_pad_len,
  output logic             rx_done,
  output logic             rx_auth_ok
);
  import framer_pkg::*;

  typedef struct packed {
    tx_st_t                    tx_st;
    logic [2:0]                tx_idx;
    logic                      tx_prot;
    logic [15:0]               tx_cnt;
    logic [7:0]                tx_pad;
    logic [7:0]                tx_plen;
    logic [2:0]                tx_j;
    logic                      tx_ready;
    logic                      tx_ov;
    logic [31:0]               tx_od;
    logic                      tx_ol;
    rx_st_t                    rx_st;
    logic [2:0]                rx_idx;
    logic                      rx_esp;
    logic [31:0]               rx_seq_new;
    logic [3:0]                rx_fill;
    logic [MAX_TRL-1:0][31:0]  line;
    logic                      rx_ov;
    logic [31:0]               rx_od;
    logic                      rx_ol;
    logic [7:0]                rx_pad;
    logic                      rx_done;
    logic                      rx_ok;
    logic [3:0]                ctrl;
    logic [31:0]               tx_spi;
    logic [31:0]               tx_seq;
    logic [31:0]               rx_spi;
    logic [31:0]               rx_seq;
    logic [2:0]                trl;
    logic [2:0]                blk_lg;
    logic [31:0]               key;
    logic [7:0]                cnt_ok;
    logic [7:0]                cnt_fail;
    logic [7:0]                cnt_replay;
    logic [7:0]                cnt_disc;
    logic [31:0]               rdata;
  } state_t;

  state_t      s_q;
  state_t      s_d;
  logic        tx_clr;
  logic        tx_en;
  logic [31:0] tx_word;
  logic [31:0] tx_acc;
  logic        rx_clr;
  logic        rx_en;
  logic [31:0] rx_word;
  logic [31:0] rx_acc;
  logic        tx_take;
  logic        rx_match;
  logic [23:0] id_dest;
  logic [23:0] id_src;

  // Trailer word j: the running check mixed with the key rotated by j.
  function automatic logic [31:0] trailer_word(input logic [31:0] a, input logic [31:0] k,
                                               input logic [2:0] j);
    logic [63:0] t;
    t = {k, k} << j;
    return a ^ t[63:32];
  endfunction

  // One accumulator per direction, so send and receive never contend.
  icv_accum #(.W(32)) u_tx_icv (
    .clk  (clk),
    .rst  (rst),
    .clr  (tx_clr),
    .en   (tx_en),
    .word (tx_word),
    .key  (s_q.key),
    .acc  (tx_acc)
  );

  icv_accum #(.W(32)) u_rx_icv (
    .clk  (clk),
    .rst  (rst),
    .clr  (rx_clr),
    .en   (rx_en),
    .word (rx_word),
    .key  (s_q.key),
    .acc  (rx_acc)
  );

  assign tx_take = tx_in_valid && s_q.tx_ready;

  // Next-state logic for both directions and the register port.
  always_comb
  begin
    logic [31:0] w;
    logic [31:0] dec;
    logic [7:0]  blk;
    logic [7:0]  pw;
    logic [15:0] cnt_n;
    logic        prot;
    int          k;
    w = 32'h0;
    dec = 32'h0;
    blk = 8'h01 << s_q.blk_lg;
    pw = 8'h0;
    cnt_n = 16'h0;
    prot = s_q.tx_prot;
    k = 0;
    s_d = s_q;
    s_d.tx_ov = 1'b0;
    s_d.tx_ol = 1'b0;
    s_d.rx_ov = 1'b0;
    s_d.rx_ol = 1'b0;
    s_d.rx_done = 1'b0;
    tx_clr = 1'b0;
    tx_en = 1'b0;
    tx_word = 32'h0;
    rx_clr = 1'b0;
    rx_en = 1'b0;
    rx_word = 32'h0;
    id_dest = `ID_SW_LINK;
    id_src = `ID_SW_LINK;
    if (s_q.ctrl[`CTRL_LT_MSB:`CTRL_LT_LSB] == `LINK_NF)
    begin
      id_dest = `ID_FABRIC;
      id_src = `ID_NODE;
    end
    else if (s_q.ctrl[`CTRL_LT_MSB:`CTRL_LT_LSB] == `LINK_FN)
    begin
      id_dest = `ID_NODE;
      id_src = `ID_FABRIC;
    end

    // Send side: header rewrite, security header, encrypt, pad, trailer.
    case (s_q.tx_st)
      T_HDR:
      begin
        if (tx_take)
        begin
          w = tx_in_data;
          if (s_q.tx_idx == `WORD_DEST)
          begin
            prot = tx_in_protect && s_q.ctrl[`CTRL_TX_EN];
            s_d.tx_prot = prot;
          end
          if (prot && s_q.tx_idx == `WORD_DEST)
            w[`ID_MSB:`ID_LSB] = id_dest;
          if (prot && s_q.tx_idx == `WORD_SRC)
            w[`ID_MSB:`ID_LSB] = id_src;
          if (prot && s_q.tx_idx == `WORD_CTL)
            w[`CTL_MSB:`CTL_LSB] = `ESP_CTL;
          s_d.tx_ov = 1'b1;
          s_d.tx_od = w;
          tx_clr = (s_q.tx_idx == `WORD_DEST);
          tx_en = 1'b1;
          tx_word = w;
          if (!prot)
          begin
            s_d.tx_ol = tx_in_last;
            s_d.tx_idx = 3'h0;
            s_d.tx_st = tx_in_last ? T_HDR : T_RAW;
          end
          else if (s_q.tx_idx == `WORD_HDR_LAST)
          begin
            s_d.tx_idx = 3'h0;
            s_d.tx_ready = 1'b0;
            s_d.tx_st = T_SPI;
          end
          else
            s_d.tx_idx = s_q.tx_idx + 3'h1;
        end
      end
      T_RAW:
      begin
        if (tx_take)
        begin
          s_d.tx_ov = 1'b1;
          s_d.tx_od = tx_in_data;
          s_d.tx_ol = tx_in_last;
          if (tx_in_last)
            s_d.tx_st = T_HDR;
        end
      end
      T_SPI:
      begin
        s_d.tx_ov = 1'b1;
        s_d.tx_od = s_q.tx_spi;
        tx_en = 1'b1;
        tx_word = s_q.tx_spi;
        s_d.tx_st = T_SEQ;
      end
      T_SEQ:
      begin
        s_d.tx_ov = 1'b1;
        s_d.tx_od = s_q.tx_seq;
        tx_en = 1'b1;
        tx_word = s_q.tx_seq;
        s_d.tx_seq = s_q.tx_seq + 32'h1;
        s_d.tx_cnt = 16'h0;
        s_d.tx_ready = 1'b1;
        s_d.tx_st = T_BODY;
      end
      T_BODY:
      begin
        if (tx_take)
        begin
          w = tx_in_data ^ tx_key_word;
          s_d.tx_ov = 1'b1;
          s_d.tx_od = w;
          tx_en = 1'b1;
          tx_word = w;
          cnt_n = s_q.tx_cnt + 16'h1;
          s_d.tx_cnt = cnt_n;
          if (tx_in_last)
          begin
            pw = blk - (cnt_n[7:0] & (blk - 8'h01));
            s_d.tx_pad = pw;
            s_d.tx_plen = 8'({pw, 2'b00} - `PADLEN_ADJ);
            s_d.tx_ready = 1'b0;
            s_d.tx_st = T_PAD;
          end
        end
      end
      T_PAD:
      begin
        w = 32'h0;
        if (s_q.tx_pad == 8'h01)
          w[`PADLEN_MSB:`PADLEN_LSB] = s_q.tx_plen;
        w = w ^ tx_key_word;
        s_d.tx_ov = 1'b1;
        s_d.tx_od = w;
        tx_en = 1'b1;
        tx_word = w;
        s_d.tx_cnt = s_q.tx_cnt + 16'h1;
        s_d.tx_pad = s_q.tx_pad - 8'h01;
        if (s_q.tx_pad == 8'h01)
        begin
          s_d.tx_j = 3'h0;
          s_d.tx_st = T_ICV;
        end
      end
      T_ICV:
      begin
        s_d.tx_ov = 1'b1;
        s_d.tx_od = trailer_word(tx_acc, s_q.key, s_q.tx_j);
        s_d.tx_j = s_q.tx_j + 3'h1;
        if (s_q.tx_j == s_q.trl - 3'h1)
        begin
          s_d.tx_ol = 1'b1;
          s_d.tx_ready = 1'b1;
          s_d.tx_st = T_HDR;
        end
      end
      default:
        s_d.tx_st = T_HDR;
    endcase

    // Trailer compare: line[0] holds the newest word, so trailer word j sits at trl-1-j.
    rx_match = 1'b1;
    for (int j = 0; j < MAX_TRL; j++)
    begin
      k = int'(s_q.trl) - 1 - j;
      if (k >= 0 && s_q.line[k] != trailer_word(rx_acc, s_q.key, 3'(j)))
        rx_match = 1'b0;
    end

    // Receive side; the trailer is held back in a short line until the frame ends.
    case (s_q.rx_st)
      R_HDR:
      begin
        if (rx_in_valid)
        begin
          rx_clr = (s_q.rx_idx == `WORD_DEST);
          rx_en = 1'b1;
          rx_word = rx_in_data;
          if (s_q.rx_idx == `WORD_CTL)
            s_d.rx_esp = rx_in_data[`CTL_LSB + `ESP_BIT];
          s_d.rx_idx = s_q.rx_idx + 3'h1;
          if (s_q.rx_idx == `WORD_HDR_LAST)
          begin
            s_d.rx_idx = 3'h0;
            if (!s_q.rx_esp)
              s_d.rx_st = R_PASS;
            else if (!s_q.ctrl[`CTRL_RX_SUP])
            begin
              s_d.rx_st = R_DISC;
              s_d.cnt_disc = s_q.cnt_disc + 8'h01;
            end
            else
              s_d.rx_st = R_SPI;
          end
        end
      end
      R_SPI:
      begin
        if (rx_in_valid)
        begin
          rx_en = 1'b1;
          rx_word = rx_in_data;
          s_d.rx_st = (rx_in_data == s_q.rx_spi) ? R_SEQ : R_DISC;
          if (rx_in_data != s_q.rx_spi)
            s_d.cnt_disc = s_q.cnt_disc + 8'h01;
        end
      end
      R_SEQ:
      begin
        if (rx_in_valid)
        begin
          rx_en = 1'b1;
          rx_word = rx_in_data;
          s_d.rx_seq_new = rx_in_data;
          s_d.rx_fill = 4'h0;
          s_d.rx_st = (rx_in_data > s_q.rx_seq) ? R_BODY : R_DISC;
          if (rx_in_data <= s_q.rx_seq)
            s_d.cnt_replay = s_q.cnt_replay + 8'h01;
        end
      end
      R_BODY:
      begin
        if (rx_in_valid)
        begin
          s_d.line = {s_q.line[MAX_TRL-2:0], rx_in_data};
          if (s_q.rx_fill == {1'b0, s_q.trl})
          begin
            rx_en = 1'b1;
            rx_word = s_q.line[s_q.trl - 3'h1];
            dec = s_q.line[s_q.trl - 3'h1] ^ rx_key_word;
            s_d.rx_ov = 1'b1;
            s_d.rx_od = dec;
            s_d.rx_ol = rx_in_last;
            if (rx_in_last)
              s_d.rx_pad = dec[`PADLEN_MSB:`PADLEN_LSB];
          end
          else
            s_d.rx_fill = s_q.rx_fill + 4'h1;
          if (rx_in_last)
          begin
            if (s_q.rx_fill != {1'b0, s_q.trl})
              s_d.rx_fill = 4'h0;
            s_d.rx_st = R_CHK;
          end
        end
      end
      R_CHK:
      begin
        s_d.rx_done = 1'b1;
        s_d.rx_ok = rx_match && (s_q.rx_fill == {1'b0, s_q.trl});
        if (s_d.rx_ok)
        begin
          s_d.rx_seq = s_q.rx_seq_new;
          s_d.cnt_ok = s_q.cnt_ok + 8'h01;
        end
        else
          s_d.cnt_fail = s_q.cnt_fail + 8'h01;
        s_d.rx_st = R_HDR;
      end
      R_PASS:
      begin
        if (rx_in_valid)
        begin
          s_d.rx_ov = 1'b1;
          s_d.rx_od = rx_in_data;
          s_d.rx_ol = rx_in_last;
          if (rx_in_last)
            s_d.rx_st = R_HDR;
        end
      end
      R_DISC:
      begin
        if (rx_in_valid && rx_in_last)
          s_d.rx_st = R_HDR;
      end
      default:
        s_d.rx_st = R_HDR;
    endcase

    // Register port; software writes land last so they win over sequencer updates.
    s_d.rdata = 32'h0;
    if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_CTRL:   s_d.rdata = {28'h0, s_q.ctrl};
        `ADDR_TX_SPI: s_d.rdata = s_q.tx_spi;
        `ADDR_TX_SEQ: s_d.rdata = s_q.tx_seq;
        `ADDR_RX_SPI: s_d.rdata = s_q.rx_spi;
        `ADDR_RX_SEQ: s_d.rdata = s_q.rx_seq;
        `ADDR_PARAM:  s_d.rdata = {25'h0, s_q.blk_lg, 1'b0, s_q.trl};
        `ADDR_KEY:    s_d.rdata = 32'h0;
        `ADDR_STATUS: s_d.rdata = {s_q.cnt_disc, s_q.cnt_replay, s_q.cnt_fail, s_q.cnt_ok};
        default:      s_d.rdata = 32'h0;
      endcase
    end
    if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_CTRL:   s_d.ctrl = reg_wdata[3:0];
        `ADDR_TX_SPI: s_d.tx_spi = reg_wdata;
        `ADDR_TX_SEQ: s_d.tx_seq = reg_wdata;
        `ADDR_RX_SPI: s_d.rx_spi = reg_wdata;
        `ADDR_RX_SEQ: s_d.rx_seq = reg_wdata;
        `ADDR_KEY:    s_d.key = reg_wdata;
        `ADDR_PARAM:
        begin
          // Clamping keeps the pad inside 2..254 bytes and the trailer inside the line.
          s_d.trl = reg_wdata[`PRM_TRL_MSB:`PRM_TRL_LSB];
          if (s_d.trl == 3'h0)
            s_d.trl = 3'h1;
          if (int'(s_d.trl) > MAX_TRL)
            s_d.trl = 3'(MAX_TRL);
          s_d.blk_lg = reg_wdata[`PRM_BLK_MSB:`PRM_BLK_LSB];
          if (s_d.blk_lg > `PRM_BLK_MAX)
            s_d.blk_lg = `PRM_BLK_MAX;
        end
        default:
        begin
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.ctrl <= `CTRL_RST;
      s_q.trl <= `TRL_RST;
      s_q.blk_lg <= `BLK_RST;
      s_q.tx_ready <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Every output comes straight from the state flops.
  assign reg_rdata = s_q.rdata;
  assign tx_in_ready = s_q.tx_ready;
  assign tx_out_valid = s_q.tx_ov;
  assign tx_out_data = s_q.tx_od;
  assign tx_out_last = s_q.tx_ol;
  assign rx_out_valid = s_q.rx_ov;
  assign rx_out_data = s_q.rx_od;
  assign rx_out_last = s_q.rx_ol;
  assign rx_out_pad_len = s_q.rx_pad;
  assign rx_done = s_q.rx_done;
  assign rx_auth_ok = s_q.rx_ok;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_sw_dest: assert property (tx_take && s_q.tx_st == T_HDR && s_q.tx_idx == 3'h0
    && tx_in_protect && s_q.ctrl == 4'hC |=> tx_out_data[23:0] == 24'h0FFFFD)
    else $error("switch link destination identifier wrong");
  a_nf_src: assert property (tx_take && s_q.tx_st == T_HDR && s_q.tx_idx == 3'h1
    && s_q.tx_prot && s_q.ctrl[1:0] == 2'h1 |=> tx_out_data[23:0] == 24'h0FFFF0)
    else $error("node link source identifier wrong");
  a_fn_dest: assert property (tx_take && s_q.tx_st == T_HDR && s_q.tx_idx == 3'h0
    && tx_in_protect && s_q.ctrl == 4'hE |=> tx_out_data[23:0] == 24'h0FFFF0)
    else $error("fabric link destination identifier wrong");
  a_ctl_only: assert property (tx_take && s_q.tx_st == T_HDR && s_q.tx_idx == 3'h3
    && s_q.tx_prot |=> tx_out_data[23:16] == 8'h40)
    else $error("control field carries bits beside the security bit");
  a_sec_header: assert property (s_q.tx_st == T_SPI && !reg_wr |=> tx_out_valid
    && tx_out_data == $past(s_q.tx_spi) ##1 tx_out_data == $past(s_q.tx_seq))
    else $error("security header words out of place");
  a_pad_align: assert property (s_q.tx_st == T_ICV && s_q.tx_j == 3'h0
    |-> (s_q.tx_cnt[7:0] & ((8'h01 << s_q.blk_lg) - 8'h01)) == 8'h00)
    else $error("padded content not a whole block");
  a_trailer_end: assert property (s_q.tx_st == T_ICV && s_q.tx_j == s_q.trl - 3'h1
    |=> tx_out_valid && tx_out_last && s_q.tx_st == T_HDR)
    else $error("trailer length differs from the negotiated one");
  a_replay_drop: assert property (s_q.rx_st == R_SEQ && rx_in_valid
    && rx_in_data <= s_q.rx_seq |=> s_q.rx_st == R_DISC && !rx_out_valid)
    else $error("replayed frame not rejected");
  a_auth_result: assert property (s_q.rx_st == R_CHK
    |=> rx_done && rx_auth_ok == $past(rx_match && s_q.rx_fill == {1'b0, s_q.trl}))
    else $error("authentication verdict does not follow the compare");
  a_discard_quiet: assert property (s_q.rx_st == R_DISC |=> !rx_out_valid)
    else $error("discarded frame leaked to the output");

  c_tx_frame: cover property (s_q.tx_st == T_ICV ##1 tx_out_last);
  c_rx_good: cover property (rx_done && rx_auth_ok);
  c_rx_bad: cover property (rx_done && !rx_auth_ok);
  c_rx_replay: cover property (s_q.rx_st == R_SEQ ##1 s_q.rx_st == R_DISC);

endmodule

// ---- dv/esp_peer.sv ----
// Peer link port model that feeds protected frames into the receive path.
`timescale 1ns/100ps
`include "framer_consts.svh"
module esp_peer #(
  parameter logic [31:0] KEY = 32'h0,
  parameter logic [31:0] KS  = 32'h0
) (
  input  wire logic        clk,
  output logic             rx_in_valid,
  output logic      [31:0] rx_in_data,
  output logic             rx_in_last
);
  // One rotate-and-mix step of the stand-in authenticator.
  function automatic logic [31:0] step(input logic [31:0] a, w, k);
    return {a[30:0], a[31]} ^ w ^ k;
  endfunction

  // Lines idle at time zero.
  initial
  begin
    rx_in_valid = 1'b0;
    rx_in_data = 32'h0;
    rx_in_last = 1'b0;
  end

  // One frame: header, security words, one body word, three pad words, one trailer word.
  task automatic send(input logic [31:0] spi, seq, input logic bad);
    logic [31:0] w[13];
    logic [31:0] a;
    w = '{{8'h52, `ID_SW_LINK}, {8'h00, `ID_SW_LINK}, 32'h0, {8'h00, `ESP_CTL, 16'h0},
          32'h0, 32'h0, spi, seq, 32'hCAFE0001, 32'h0, 32'h0, 32'h00000A00, 32'h0};
    // Body and pad go out encrypted with the shared keystream before the check is formed.
    for (int i = 8; i < 12; i++) w[i] = w[i] ^ KS;
    a = 32'h0;
    for (int i = 0; i < 12; i++) a = step(a, w[i], KEY);
    w[12] = a ^ KEY ^ {31'h0, bad};
    for (int i = 0; i < 13; i++)
    begin
      rx_in_valid <= 1'b1;
      rx_in_data <= w[i];
      rx_in_last <= (i == 12);
      @(posedge clk);
    end
    // Released data shows the inverse, so a stale word never looks current.
    rx_in_valid <= 1'b0;
    rx_in_data <= ~w[12];
    rx_in_last <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// ---- dv/link_esp_encap_framer_tb.sv ----
// Self-checking testbench for the link security-payload framer.
`timescale 1ns/100ps
`include "framer_consts.svh"
module link_esp_encap_framer_tb;
  localparam logic [31:0] K = 32'h5A5A1234;
  localparam logic [31:0] KS = 32'h0F0F0F0F;
  logic        clk, rst, reg_wr, reg_rd, tx_in_valid, tx_in_last, tx_in_protect, tx_in_ready;
  logic        tx_out_valid, tx_out_last, rx_in_valid, rx_in_last, rx_out_valid, rx_out_last;
  logic        rx_done, rx_auth_ok, ok_seen;
  logic [7:0]  reg_addr, rx_out_pad_len, pad_seen;
  logic [31:0] reg_wdata, reg_rdata, tx_in_data, tx_out_data, rx_in_data, rx_out_data;
  logic [31:0] body_seen, q[$];
  int          error_cnt, n_checks, last_at, dones, n_out;

  link_esp_encap_framer i_link_esp_encap_framer (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data), .tx_in_last(tx_in_last),
    .tx_in_protect(tx_in_protect), .tx_in_ready(tx_in_ready), .tx_key_word(KS),
    .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .tx_out_last(tx_out_last),
    .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data), .rx_in_last(rx_in_last),
    .rx_key_word(KS), .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
    .rx_out_last(rx_out_last), .rx_out_pad_len(rx_out_pad_len), .rx_done(rx_done),
    .rx_auth_ok(rx_auth_ok));
  esp_peer #(.KEY(K), .KS(KS)) i_esp_peer (.clk(clk), .rx_in_valid(rx_in_valid),
    .rx_in_data(rx_in_data), .rx_in_last(rx_in_last));

  // Clock at 100 MHz.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Collect outputs on the falling edge, where they have settled and stand once each.
  always @(negedge clk)
  begin
    if (tx_out_valid && tx_out_last) last_at = q.size();
    if (tx_out_valid) q.push_back(tx_out_data);
    if (rx_out_valid && rx_out_last) pad_seen = rx_out_pad_len;
    if (rx_done) ok_seen = rx_auth_ok;
    if (rx_done) dones++;
    if (rx_out_valid && n_out == 0) body_seen = rx_out_data;
    if (rx_out_valid) n_out++;
  end

  task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data is looked at in the one cycle where it stands.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    ck(reg_rdata, e, m);
    @(posedge clk);
  endtask

  // Sends one seven-word frame and judges the framed result.
  task automatic t_tx(input logic [1:0] lt, input logic p, input logic [23:0] dst, src,
                      input logic [31:0] seq);
    logic [31:0] w[7];
    logic [31:0] a;
    w = '{32'h22123456, 32'h00ABCDEF, 32'h0, 32'h00FF0000, 32'h0, 32'h0, 32'hBEEF0001};
    q.delete();
    wr(`ADDR_CTRL, {28'h0, 2'b11, lt});
    for (int i = 0; i < 7; i++)
    begin
      tx_in_valid <= 1'b1;
      tx_in_data <= w[i];
      tx_in_last <= (i == 6);
      tx_in_protect <= p;
      // Ready is judged where it has settled, before the edge that takes the word.
      @(negedge clk);
      while (!tx_in_ready) @(negedge clk);
      @(posedge clk);
    end
    tx_in_valid <= 1'b0;
    repeat (12) @(posedge clk);
    ck(32'(q.size()), p ? 32'd13 : 32'd7, "word count");
    ck(32'(last_at), p ? 32'd12 : 32'd6, "last flag");
    if (!p) ck(q[3], w[3], "plain frame altered");
    if (!p) return;
    ck({8'h0, q[0][23:0]}, {8'h0, dst}, "destination");
    ck({8'h0, q[1][23:0]}, {8'h0, src}, "source");
    ck({24'h0, q[3][23:16]}, {24'h0, `ESP_CTL}, "control field");
    ck(q[6], 32'h00000777, "index word");
    ck(q[7], seq, "sequence word");
    ck(q[8], w[6] ^ KS, "body word");
    ck({24'h0, q[11][15:8] ^ KS[15:8]}, 32'h0000000A, "pad length");
    a = 32'h0;
    for (int i = 0; i < 12; i++) a = i_esp_peer.step(a, q[i], K);
    ck(q[12], a ^ K, "trailer");
  endtask

  // One received frame: verdict count, verdict and delivered pad length.
  task automatic t_rx(input logic [31:0] spi, seq, input logic bad, nd, ok);
    dones = 0;
    pad_seen = 8'h0;
    n_out = 0;
    i_esp_peer.send(spi, seq, bad);
    repeat (6) @(posedge clk);
    ck(32'(dones), {31'h0, nd}, "verdict count");
    ck({24'h0, pad_seen}, nd ? 32'h0000000A : 32'h0, "pad length out");
    if (nd) ck({31'h0, ok_seen}, {31'h0, ok}, "verdict");
    ck(32'(n_out), nd ? 32'd4 : 32'd0, "delivered words");
    if (nd) ck(body_seen, 32'hCAFE0001, "decrypted body");
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog against a hung handshake.
  initial
  begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  // Main sequence.
  initial
  begin
    {rst, reg_wr, reg_rd, tx_in_valid, tx_in_last, tx_in_protect} = 6'h3F;
    {reg_wr, reg_rd, tx_in_valid, tx_in_last, tx_in_protect} = 5'h0;
    {reg_addr, reg_wdata, tx_in_data} = 72'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(`ADDR_CTRL, 32'h0000000C, "control reset");
    rd(8'h40, 32'h0, "unmapped read");
    wr(`ADDR_TX_SPI, 32'h00000777);
    wr(`ADDR_TX_SEQ, 32'h5);
    wr(`ADDR_KEY, K);
    rd(`ADDR_KEY, 32'h0, "key readback");
    t_tx(`LINK_SW, 1'b1, 24'h0FFFFD, 24'h0FFFFD, 32'h5);
    t_tx(`LINK_NF, 1'b1, 24'h0FFFFE, 24'h0FFFF0, 32'h6);
    t_tx(`LINK_FN, 1'b1, 24'h0FFFF0, 24'h0FFFFE, 32'h7);
    t_tx(`LINK_SW, 1'b0, 24'h0, 24'h0, 32'h0);
    wr(`ADDR_CTRL, 32'h0000000C);
    wr(`ADDR_RX_SPI, 32'h99);
    t_rx(32'h99, 32'h3, 1'b0, 1'b1, 1'b1);
    t_rx(32'h99, 32'h3, 1'b0, 1'b0, 1'b0);
    t_rx(32'h99, 32'h4, 1'b1, 1'b1, 1'b0);
    t_rx(32'h98, 32'h5, 1'b0, 1'b0, 1'b0);
    wr(`ADDR_CTRL, 32'h00000004);
    t_rx(32'h99, 32'h5, 1'b0, 1'b0, 1'b0);
    rd(`ADDR_STATUS, 32'h02010101, "status counts");
    report_and_stop();
  end
endmodule
